// ### design/adc_seq_pkg.sv
// Shared constants, phase encoding and pin-sync helper for the converter sequencer.
// Assumes one 50 MHz system clock; pins arrive unsynchronised.
package adc_seq_pkg;

   // System clock and analog timing
   localparam int CLK_PERIOD_NS  = 20;
   localparam int CHAN_SETTLE_NS = 500;
   localparam int BREAK_NS       = 44;
   // Longest time rounds down, least time rounds up, never below one cycle
   localparam int CHAN_SETTLE_CYC = (CHAN_SETTLE_NS / CLK_PERIOD_NS < 1) ? 1
                                    : CHAN_SETTLE_NS / CLK_PERIOD_NS;
   localparam int BREAK_CYC = ((BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1
                              : (BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

   // Data path widths
   localparam int HALF_W   = 5;
   localparam int CODE_W   = 2 * HALF_W;
   localparam int CHAN_W   = 3;
   localparam int NUM_CHAN = 8;

   // Reset values and switch patterns
   localparam logic [CHAN_W-1:0]   CHAN_RESET   = 3'h0;
   localparam logic [NUM_CHAN-1:0] SWITCH_RESET = 8'h01;
   localparam logic [NUM_CHAN-1:0] SWITCH_NONE  = 8'h00;
   localparam logic [NUM_CHAN-1:0] SWITCH_ONE   = 8'h01;

   // Bit positions in the main synchroniser vector
   localparam int PIN_CONV  = 0;
   localparam int PIN_START = 1;
   localparam int PIN_SEL   = 2;
   localparam int MAIN_PINS = 3;

   // Bit positions in the address synchroniser vector
   localparam int PIN_ALE   = 3;
   localparam int ADDR_PINS = 4;

   // Idle plus the six half periods of one conversion
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_SAMPLE,
      PH_COMPARE1,
      PH_AZ_A,
      PH_AZ_B,
      PH_AZ_C,
      PH_COMPARE2
   } phase_t;

   // Filtered level takes a change only once stages two and three agree
   function automatic logic [ADDR_PINS-1:0] settle(input logic [ADDR_PINS-1:0] s2,
                                                   input logic [ADDR_PINS-1:0] s3,
                                                   input logic [ADDR_PINS-1:0] filt);
      settle = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & filt);
   endfunction : settle

endpackage : adc_seq_pkg

// ### design/chan_mux_ctrl.sv
// Channel address latch and break-before-make input switch control.
// Assumes select is already filtered on CLK and hold_rise is a one-cycle pulse.
module chan_mux_ctrl #(
   parameter int DELAY_CYC = adc_seq_pkg::CHAN_SETTLE_CYC,
   parameter int GAP_CYC   = adc_seq_pkg::BREAK_CYC
) (
   input  wire logic                              clk,
   input  wire logic                              rst,
   input  wire logic                              ce,
   input  wire logic                              latch_open,
   input  wire logic [adc_seq_pkg::CHAN_W-1:0]    sel_bits,
   input  wire logic                              select_n,
   input  wire logic                              hold_rise,
   output logic      [adc_seq_pkg::NUM_CHAN-1:0]  switch_on,
   output logic      [adc_seq_pkg::CHAN_W-1:0]    chan_active
);

   typedef struct packed {
      logic [adc_seq_pkg::ADDR_PINS-1:0] s1;
      logic [adc_seq_pkg::ADDR_PINS-1:0] s2;
      logic [adc_seq_pkg::ADDR_PINS-1:0] s3;
      logic [adc_seq_pkg::ADDR_PINS-1:0] filt;
      logic [adc_seq_pkg::CHAN_W-1:0]    latched;
      logic [adc_seq_pkg::CHAN_W-1:0]    active;
      logic [adc_seq_pkg::NUM_CHAN-1:0]  switches;
      logic [adc_seq_pkg::CNT_W-1:0]     wait_cnt;
      logic                              waiting;
      logic [adc_seq_pkg::CNT_W-1:0]     gap_cnt;
      logic                              gapping;
   } mux_state_t;

   mux_state_t st;
   mux_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.s1 = {latch_open, sel_bits};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.filt = adc_seq_pkg::settle(st.s2, st.s3, st.filt);
      // Transparent while open and selected; last value stays after the fall
      if (next_st.filt[adc_seq_pkg::PIN_ALE] && !select_n) begin // [RULE13]
         next_st.latched = next_st.filt[adc_seq_pkg::CHAN_W-1:0]; // [RULE11]
      end
      if (st.gapping) begin
         if (st.gap_cnt == '0) begin
            next_st.gapping  = 1'b0;
            next_st.switches = adc_seq_pkg::SWITCH_ONE << st.active; // [RULE11]
         end else begin
            next_st.gap_cnt = st.gap_cnt - 1'b1;
         end
      end else if (hold_rise) begin // [RULE14]
         next_st.waiting  = 1'b1;
         next_st.wait_cnt = adc_seq_pkg::CNT_W'(DELAY_CYC - 1);
      end else if (st.waiting) begin
         if (st.wait_cnt == '0) begin
            next_st.waiting = 1'b0;
            // Old switch opens before the new one closes
            if (st.latched != st.active) begin // [RULE15]
               next_st.active   = st.latched;
               next_st.switches = adc_seq_pkg::SWITCH_NONE;
               next_st.gapping  = 1'b1;
               next_st.gap_cnt  = adc_seq_pkg::CNT_W'(GAP_CYC - 1);
            end
         end else begin
            next_st.wait_cnt = st.wait_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st          <= '0;
         st.latched  <= adc_seq_pkg::CHAN_RESET; // [RULE12]
         st.active   <= adc_seq_pkg::CHAN_RESET;
         st.switches <= adc_seq_pkg::SWITCH_RESET;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign switch_on   = st.switches;
   assign chan_active = st.active;

   default clocking @(posedge clk); endclocking
   default disable iff (rst || !ce);

   property p_break_gap;
      ($past(st.switches) != adc_seq_pkg::SWITCH_NONE && st.switches == adc_seq_pkg::SWITCH_NONE)
         |-> (st.switches == adc_seq_pkg::SWITCH_NONE) [*3];
   endproperty
   a_break_gap: assert property (p_break_gap) else $error("switch gap too short"); // [RULE15]

   property p_one_channel;
      $onehot0(st.switches) && (st.switches == adc_seq_pkg::SWITCH_NONE ||
                                st.switches == (adc_seq_pkg::SWITCH_ONE << st.active));
   endproperty
   a_one_channel: assert property (p_one_channel) else $error("bad channel switch"); // [RULE11]

   property p_reset_chan;
      $fell(rst) |-> (st.switches == adc_seq_pkg::SWITCH_RESET && st.active == '0);
   endproperty
   a_reset_chan: assert property (p_reset_chan) else $error("channel zero not set"); // [RULE12]

   cover property (st.gapping && st.gap_cnt == '0);

endmodule : chan_mux_ctrl

// ### design/two_step_adc_sequencer.sv
// Sequencer for an eight-input two-step flash converter: phases, latches, channel.
// Assumes a free conversion clock pin and comparator codes settled at its edges.
// Function
// RULE1: Conversion lasts exactly three conversion clock periods
// RULE2: Hold one period, then acquire two periods
// RULE3: Next sample starts as previous conversion ends
// RULE4: First half auto-zero, second half compare
// RULE5: Coarse code ready at third half period
// RULE6: Coarse code into stage one upper half
// RULE7: Auto-zero halves three to five, compare sixth
// RULE8: Fine code into stage one lower half
// RULE9: End of conversion loads stage two latch
// RULE10: Result presented in two's complement
// RULE11: Three-bit address selects one of eight
// RULE12: Power-up selects input channel zero
// RULE13: Address transparent when open, captured on fall
// RULE14: New channel applies 500 ns after hold
// RULE15: Break before make, 44 ns gap
// RULE16: Hold timing driven out on a pin
// RULE17: Conversion clock 10 kHz to 800 kHz
// RULE18: Convert request low starts, held low repeats
// RULE19: Done pulses high at conversion end
// RULE20: Hold output pulses low at start
// RULE21: Out-of-range valid at end of conversion
// RULE22: Phases from conversion clock; stage two only
module two_step_adc_sequencer (
   input  wire logic                                  CLK,
   input  wire logic                                  RST,
   input  wire logic                                  CE,
   input  wire logic                                  CONV_CLK,
   input  wire logic                                  START_N,
   input  wire logic                                  SELECT_N,
   input  wire logic                                  LATCH_OPEN,
   input  wire logic                                  CHANNEL_SEL_BIT0,
   input  wire logic                                  CHANNEL_SEL_BIT1,
   input  wire logic                                  CHANNEL_SEL_BIT2,
   input  wire logic [adc_seq_pkg::HALF_W-1:0]        COARSE_CODE,
   input  wire logic                                  COARSE_OVER,
   input  wire logic [adc_seq_pkg::HALF_W-1:0]        FINE_CODE,
   output logic                                       HOLD_N,
   output logic                                       TRACK_HOLD,
   output logic                                       AUTOZERO,
   output logic                                       COMPARE,
   output logic                                       RESIDUE_AMP,
   output logic      [adc_seq_pkg::HALF_W-1:0]        LADDER_TAP_LEVEL,
   output logic      [adc_seq_pkg::CODE_W-1:0]        RESULT,
   output logic                                       RANGE_EXCEEDED,
   output logic                                       DONE,
   output logic      [adc_seq_pkg::NUM_CHAN-1:0]      CHANNEL_ON,
   output logic      [adc_seq_pkg::CHAN_W-1:0]        CHANNEL_ACTIVE
);

   typedef struct packed {
      logic [adc_seq_pkg::MAIN_PINS-1:0] s1;
      logic [adc_seq_pkg::MAIN_PINS-1:0] s2;
      logic [adc_seq_pkg::MAIN_PINS-1:0] s3;
      logic [adc_seq_pkg::MAIN_PINS-1:0] filt;
      adc_seq_pkg::phase_t               phase;
      logic                              req;
      logic [adc_seq_pkg::HALF_W-1:0]    upper;
      logic                              over;
      logic [adc_seq_pkg::HALF_W-1:0]    lower;
      logic [adc_seq_pkg::CODE_W-1:0]    result;
      logic                              range_exceeded;
      logic                              done;
      logic                              hold;
      logic                              autozero;
      logic                              compare;
      logic                              residue;
   } conv_state_t;

   conv_state_t st;
   conv_state_t next_st;
   logic        conv_rise;
   logic        conv_fall;
   logic        want;
   logic        start;
   logic        hold_rise;
   logic [adc_seq_pkg::ADDR_PINS-1:0] settled;

   always_comb begin
      next_st = st;
      next_st.s1 = {SELECT_N, START_N, CONV_CLK};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      settled = adc_seq_pkg::settle({1'b0, st.s2}, {1'b0, st.s3}, {1'b0, st.filt});
      next_st.filt = settled[adc_seq_pkg::MAIN_PINS-1:0];
      // Every phase step hangs off a filtered conversion clock edge
      conv_rise = next_st.filt[adc_seq_pkg::PIN_CONV] & ~st.filt[adc_seq_pkg::PIN_CONV]; // [RULE22]
      conv_fall = ~next_st.filt[adc_seq_pkg::PIN_CONV] & st.filt[adc_seq_pkg::PIN_CONV];
      // Short low pulse is remembered; held low keeps it asserted
      want = ~st.filt[adc_seq_pkg::PIN_START] & ~st.filt[adc_seq_pkg::PIN_SEL]; // [RULE18]
      start = conv_rise && st.req &&
              (st.phase == adc_seq_pkg::PH_IDLE || st.phase == adc_seq_pkg::PH_COMPARE2);
      next_st.done = 1'b0;
      // Request taken at start; a request still present wins over the clear
      if (want) begin
         next_st.req = 1'b1;
      end else if (start) begin
         next_st.req = 1'b0;
      end
      unique case (st.phase)
         adc_seq_pkg::PH_IDLE: begin
            if (start) begin
               next_st.phase = adc_seq_pkg::PH_SAMPLE; // [RULE1]
            end
         end
         adc_seq_pkg::PH_SAMPLE: begin
            if (conv_fall) begin
               next_st.phase = adc_seq_pkg::PH_COMPARE1; // [RULE4]
            end
         end
         adc_seq_pkg::PH_COMPARE1: begin
            if (conv_rise) begin
               next_st.phase = adc_seq_pkg::PH_AZ_A; // [RULE5]
               next_st.upper = COARSE_CODE; // [RULE6]
               next_st.over  = COARSE_OVER;
            end
         end
         adc_seq_pkg::PH_AZ_A: begin
            if (conv_fall) begin
               next_st.phase = adc_seq_pkg::PH_AZ_B; // [RULE7]
            end
         end
         adc_seq_pkg::PH_AZ_B: begin
            if (conv_rise) begin
               next_st.phase = adc_seq_pkg::PH_AZ_C;
            end
         end
         adc_seq_pkg::PH_AZ_C: begin
            if (conv_fall) begin
               next_st.phase = adc_seq_pkg::PH_COMPARE2; // [RULE7]
            end
         end
         adc_seq_pkg::PH_COMPARE2: begin
            if (conv_rise) begin
               next_st.lower = FINE_CODE; // [RULE8]
               // Stage two loads only here, so pins never show a half result
               next_st.result = {~st.upper[adc_seq_pkg::HALF_W-1],
                                 st.upper[adc_seq_pkg::HALF_W-2:0],
                                 FINE_CODE}; // [RULE9] [RULE10] [RULE22]
               next_st.range_exceeded = st.over; // [RULE21]
               next_st.done  = 1'b1; // [RULE19]
               // Overlap: the edge that ends one conversion samples the next
               next_st.phase = start ? adc_seq_pkg::PH_SAMPLE : adc_seq_pkg::PH_IDLE; // [RULE3]
            end
         end
         default: begin
            next_st.phase = adc_seq_pkg::PH_IDLE;
         end
      endcase
      next_st.hold = (next_st.phase == adc_seq_pkg::PH_SAMPLE) ||
                     (next_st.phase == adc_seq_pkg::PH_COMPARE1); // [RULE2]
      next_st.autozero = (next_st.phase == adc_seq_pkg::PH_SAMPLE) ||
                         (next_st.phase == adc_seq_pkg::PH_AZ_A) ||
                         (next_st.phase == adc_seq_pkg::PH_AZ_B) ||
                         (next_st.phase == adc_seq_pkg::PH_AZ_C); // [RULE4] [RULE7]
      next_st.compare = (next_st.phase == adc_seq_pkg::PH_COMPARE1) ||
                        (next_st.phase == adc_seq_pkg::PH_COMPARE2);
      next_st.residue = (next_st.phase == adc_seq_pkg::PH_AZ_A) ||
                        (next_st.phase == adc_seq_pkg::PH_AZ_B) ||
                        (next_st.phase == adc_seq_pkg::PH_AZ_C) ||
                        (next_st.phase == adc_seq_pkg::PH_COMPARE2);
      hold_rise = CE & st.hold & ~next_st.hold;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st       <= '0;
         // Idle-high pins start inactive so reset cannot fake a request
         st.s1    <= '1;
         st.s2    <= '1;
         st.s3    <= '1;
         st.filt  <= '1;
      end else if (CE) begin
         st <= next_st;
      end
   end

   chan_mux_ctrl #(
      .DELAY_CYC (adc_seq_pkg::CHAN_SETTLE_CYC),
      .GAP_CYC   (adc_seq_pkg::BREAK_CYC)
   ) u_chan (
      .clk         (CLK),
      .rst         (RST),
      .ce          (CE),
      .latch_open  (LATCH_OPEN),
      .sel_bits    ({CHANNEL_SEL_BIT2, CHANNEL_SEL_BIT1, CHANNEL_SEL_BIT0}),
      .select_n    (st.filt[adc_seq_pkg::PIN_SEL]),
      .hold_rise   (hold_rise),
      .switch_on   (CHANNEL_ON),
      .chan_active (CHANNEL_ACTIVE)
   );

   assign HOLD_N           = ~st.hold; // [RULE16] [RULE20]
   assign TRACK_HOLD       = st.hold;
   assign AUTOZERO         = st.autozero;
   assign COMPARE          = st.compare;
   assign RESIDUE_AMP      = st.residue;
   assign LADDER_TAP_LEVEL = st.upper;
   assign RESULT           = st.result;
   assign RANGE_EXCEEDED   = st.range_exceeded;
   assign DONE             = st.done;

   // Helper: conversion clock rises seen since the last start
   logic [1:0] rise_cnt;
   always_ff @(posedge CLK) begin
      if (RST) begin
         rise_cnt <= 2'h0;
      end else if (CE) begin
         if (start) begin
            rise_cnt <= 2'h0;
         end else if (conv_rise && st.phase != adc_seq_pkg::PH_IDLE) begin
            rise_cnt <= rise_cnt + 2'h1;
         end
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (RST || !CE);

   property p_three_periods;
      DONE |-> $past(rise_cnt) == 2'h2;
   endproperty
   a_three_periods: assert property (p_three_periods) else $error("conversion not 3 clocks"); // [RULE1]

   property p_hold_edges;
      ($fell(HOLD_N) || $rose(HOLD_N)) |-> $past(conv_rise);
   endproperty
   a_hold_edges: assert property (p_hold_edges) else $error("hold edge off clock rise"); // [RULE2]

   property p_compare_half;
      $rose(COMPARE) |-> (!AUTOZERO && $past(conv_fall));
   endproperty
   a_compare_half: assert property (p_compare_half) else $error("compare phase wrong"); // [RULE4]

   property p_coarse_latch;
      $rose(RESIDUE_AMP) |-> (LADDER_TAP_LEVEL == $past(COARSE_CODE) && HOLD_N);
   endproperty
   a_coarse_latch: assert property (p_coarse_latch) else $error("coarse code not latched"); // [RULE6]

   property p_result_only_at_done;
      !$stable(RESULT) |-> DONE;
   endproperty
   a_result_only_at_done: assert property (p_result_only_at_done) else $error("result moved"); // [RULE22]

   property p_twos_complement;
      DONE |-> (RESULT == {~$past(LADDER_TAP_LEVEL[adc_seq_pkg::HALF_W-1]),
                           $past(LADDER_TAP_LEVEL[adc_seq_pkg::HALF_W-2:0]),
                           $past(FINE_CODE)} && RANGE_EXCEEDED == $past(st.over));
   endproperty
   a_twos_complement: assert property (p_twos_complement) else $error("bad result code"); // [RULE10]

   property p_done_pulse;
      DONE |=> !DONE;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle"); // [RULE19]

   property p_back_to_back;
      (conv_rise && st.phase == adc_seq_pkg::PH_COMPARE2 && st.req) |=> (DONE && !HOLD_N);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("no pipelined restart"); // [RULE3]

   // Hold must end exactly where the residue phase begins
   property p_hold_release;
      $rose(HOLD_N) |-> st.phase == adc_seq_pkg::PH_AZ_A;
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("hold not one period"); // [RULE2]

   property p_hold_start;
      $fell(HOLD_N) |-> (AUTOZERO && !COMPARE && !RESIDUE_AMP && $past(st.req));
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("hold start wrong"); // [RULE20]

   property p_coarse_ready;
      $rose(RESIDUE_AMP) |-> ($past(conv_rise) && $past(st.phase) == adc_seq_pkg::PH_COMPARE1);
   endproperty
   a_coarse_ready: assert property (p_coarse_ready) else $error("coarse off third half"); // [RULE5]

   property p_residue_autozero;
      (RESIDUE_AMP && !COMPARE) |-> AUTOZERO;
   endproperty
   a_residue_autozero: assert property (p_residue_autozero) else $error("residue not zeroed"); // [RULE7]

   property p_fine_latch;
      DONE |-> st.lower == $past(FINE_CODE);
   endproperty
   a_fine_latch: assert property (p_fine_latch) else $error("fine code not latched"); // [RULE8]

   property p_range_hold;
      !$stable(RANGE_EXCEEDED) |-> DONE;
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range flag moved"); // [RULE21]

   // Idle keeps the comparators parked, so a late start cannot half-run
   property p_idle_quiet;
      st.phase == adc_seq_pkg::PH_IDLE |-> (HOLD_N && !AUTOZERO && !COMPARE && !RESIDUE_AMP);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("phase outputs while idle"); // [RULE1]

   cover property (DONE);
   cover property (DONE && !HOLD_N);
   cover property (DONE && RANGE_EXCEEDED);

endmodule : two_step_adc_sequencer

// ### sim/host_model.sv
// Host side of the sequencer: conversion clock source plus select, request and address pins.
// Assumes the bench calls its tasks one at a time; task-driven pins change only after rising CLK edges.
module host_model (
   input  wire logic                           clk,
   output logic                                conv_clk,
   output logic                                start_n,
   output logic                                select_n,
   output logic                                latch_open,
   output logic [adc_seq_pkg::CHAN_W-1:0]      sel_bits
);
   timeunit 1ns;
   timeprecision 100ps;

   // 781.25 kHz, free running, phase offset from CLK on purpose
   initial begin
      conv_clk   = 1'h0;
      start_n    = 1'h1;
      select_n   = 1'h1;
      latch_open = 1'h0;
      sel_bits   = 3'h0;
      #7;
      forever #640 conv_clk = ~conv_clk;
   end

   // Address is scrambled after the latch closes, so a leaky latch shows up
   task automatic set_channel(input logic [2:0] ch);
      @(posedge clk);
      select_n   <= 1'h0;
      latch_open <= 1'h1;
      sel_bits   <= ch;
      repeat (6) @(posedge clk);
      latch_open <= 1'h0;
      repeat (6) @(posedge clk);
      sel_bits   <= ~ch;
   endtask : set_channel

   // Short pulse for one conversion, or held low for a stream
   task automatic request(input bit keep, input logic sel_n);
      @(posedge clk);
      select_n <= sel_n;
      start_n  <= 1'h0;
      if (!keep) begin
         repeat (6) @(posedge clk);
         start_n <= 1'h1;
      end
   endtask : request

   task automatic release_req;
      @(posedge clk);
      start_n <= 1'h1;
   endtask : release_req
endmodule : host_model

// ### sim/two_step_adc_sequencer_tb.sv
// Self-checking bench for the two-step converter sequencer.
// Assumes host_model drives the pins; comparator codes come from this bench.
`define CHECK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
   miscompares++; $display("ERROR %s expected %h seen %h", what, exp, got); end end

module two_step_adc_sequencer_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic       clk;
   logic       rst;
   logic       conv_clk;
   logic       start_n;
   logic       select_n;
   logic       latch_open;
   logic [2:0] sel_bits;
   logic [4:0] coarse;
   logic       over;
   logic [4:0] fine;
   logic       hold_n;
   logic       track_hold;
   logic       autozero;
   logic       compare;
   logic       residue;
   logic [4:0] ladder;
   logic [9:0] result;
   logic       range_exc;
   logic       done;
   logic [7:0] channel_on;
   logic [2:0] channel_active;
   logic [9:0] prev_res;
   logic [2:0] cur_ch;
   int         miscompares;
   int         samples_checked;

   host_model i_host (.clk(clk), .conv_clk(conv_clk), .start_n(start_n), .select_n(select_n),
                      .latch_open(latch_open), .sel_bits(sel_bits));

   two_step_adc_sequencer i_dut (
      .CLK(clk), .RST(rst), .CE(1'h1), .CONV_CLK(conv_clk), .START_N(start_n),
      .SELECT_N(select_n), .LATCH_OPEN(latch_open), .CHANNEL_SEL_BIT0(sel_bits[0]),
      .CHANNEL_SEL_BIT1(sel_bits[1]), .CHANNEL_SEL_BIT2(sel_bits[2]), .COARSE_CODE(coarse),
      .COARSE_OVER(over), .FINE_CODE(fine), .HOLD_N(hold_n), .TRACK_HOLD(track_hold),
      .AUTOZERO(autozero), .COMPARE(compare), .RESIDUE_AMP(residue),
      .LADDER_TAP_LEVEL(ladder), .RESULT(result), .RANGE_EXCEEDED(range_exc), .DONE(done),
      .CHANNEL_ON(channel_on), .CHANNEL_ACTIVE(channel_active));

   initial clk = 1'h0;
   always #10 clk = ~clk;

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : complete_run

   // One whole conversion from the hold fall; conversion clock is 64 CLK per period
   task automatic do_conversion(input logic [4:0] c, input logic o, input logic [4:0] f,
                                input logic [2:0] new_ch);
      int         n;
      int         guard;
      logic [7:0] old_on;
      logic [7:0] gap_on;
      old_on = 8'h01 << cur_ch;
      gap_on = (new_ch == cur_ch) ? old_on : 8'h00;
      guard  = 0;
      while (hold_n !== 1'h0 && guard < 400) begin
         @(negedge clk);
         guard++;
      end
      `CHECK("hold start", 1'h0, hold_n)
      for (n = 1; n <= 192; n++) begin
         @(posedge clk);
         if (n == 1) begin
            coarse <= c;
            over   <= o;
            fine   <= f;
         end
         @(negedge clk);
         case (n)
            1:  `CHECK("first half", 3'h5, {autozero, compare, track_hold})
            33: `CHECK("second half", 2'h1, {autozero, compare})
            63: `CHECK("hold one period", 1'h0, hold_n)
            64: begin
               `CHECK("acquire", 2'h2, {hold_n, track_hold})
               `CHECK("residue autozero", 3'h5, {autozero, compare, residue})
               `CHECK("coarse latch", c, ladder)
            end
            88: `CHECK("old switch", old_on, channel_on)
            89: `CHECK("break gap", gap_on, channel_on)
            91: `CHECK("break end", gap_on, channel_on)
            92: `CHECK("new switch", {8'h01 << new_ch, new_ch}, {channel_on, channel_active})
            161: `CHECK("fine compare", 3'h3, {autozero, compare, residue})
            191: `CHECK("stage two held", {1'h0, prev_res}, {done, result})
            192: begin
               `CHECK("done", 1'h1, done)
               `CHECK("result", {~c[4], c[3:0], f}, result)
               `CHECK("range", o, range_exc)
            end
            default: ;
         endcase
      end
      prev_res = {~c[4], c[3:0], f};
      cur_ch   = new_ch;
   endtask : do_conversion

   task automatic reset_values;
      `CHECK("reset channel", {8'h01, 3'h0}, {channel_on, channel_active})
      `CHECK("reset outputs", 13'h1000, {hold_n, done, range_exc, result})
   endtask : reset_values

   // Boundary codes: full scale with range flag, zero, mid scale
   task automatic single_shots;
      i_host.request(0, 1'h0);
      do_conversion(5'h1f, 1'h1, 5'h1f, 3'h0);
      @(negedge clk);
      `CHECK("done width", 1'h0, done)
      i_host.request(0, 1'h0);
      do_conversion(5'h00, 1'h0, 5'h00, 3'h0);
      i_host.request(0, 1'h0);
      do_conversion(5'h10, 1'h1, 5'h0a, 3'h0);
   endtask : single_shots

   // Held request: conversions chain with no idle cycle; the request remembered at release runs one more, then they stop
   task automatic continuous;
      i_host.request(1, 1'h0);
      do_conversion(5'h05, 1'h0, 5'h1a, 3'h0);
      `CHECK("back to back", 1'h0, hold_n)
      fork
         do_conversion(5'h1a, 1'h0, 5'h05, 3'h0);
         begin
            repeat (100) @(posedge clk);
            i_host.release_req();
         end
      join
      do_conversion(5'h0f, 1'h1, 5'h11, 3'h0);
      repeat (70) @(negedge clk);
      `CHECK("stream stopped", 1'h1, hold_n)
   endtask : continuous

   task automatic deselected_request;
      int lows;
      lows = 0;
      i_host.request(0, 1'h1);
      repeat (300) begin
         @(negedge clk);
         if (hold_n !== 1'h1) lows++;
      end
      `CHECK("deselected hold lows", 0, lows)
   endtask : deselected_request

   // Every channel once, in a scattered order, ending back on channel zero
   task automatic channel_walk;
      logic [2:0] ch;
      for (int i = 0; i < 8; i++) begin
         ch = 3'((i * 3 + 3) % 8);
         i_host.set_channel(ch);
         i_host.request(0, 1'h0);
         do_conversion({ch, 2'h1}, 1'h0, {2'h2, ch}, ch);
      end
   endtask : channel_walk

   initial begin
      miscompares     = 0;
      samples_checked = 0;
      prev_res        = 10'h000;
      cur_ch          = 3'h0;
      rst             = 1'h1;
      coarse          = 5'h00;
      over            = 1'h0;
      fine            = 5'h00;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      reset_values();
      single_shots();
      continuous();
      deselected_request();
      channel_walk();
      complete_run();
   end

   // Whole sequence needs about 3800 cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("ERROR watchdog expected end seen timeout");
      complete_run();
   end
endmodule : two_step_adc_sequencer_tb
